// File: rtl/ebld_pkg.sv
// Shared encodings, opcodes and timing figures of the 8-bit load decoder
package ebld_pkg;
	localparam logic [2:0] EBLD_R_B = 3'h0;
	localparam logic [2:0] EBLD_R_C = 3'h1;
	localparam logic [2:0] EBLD_R_D = 3'h2;
	localparam logic [2:0] EBLD_R_E = 3'h3;
	localparam logic [2:0] EBLD_R_H = 3'h4;
	localparam logic [2:0] EBLD_R_L = 3'h5;
	localparam logic [2:0] EBLD_R_MEM = 3'h6;
	localparam logic [2:0] EBLD_R_A = 3'h7;
	localparam logic [1:0] EBLD_P_BC = 2'h0;
	localparam logic [1:0] EBLD_P_DE = 2'h1;
	localparam logic [1:0] EBLD_P_HL = 2'h2;
	localparam logic [1:0] EBLD_P_SP = 2'h3;
	localparam logic [7:0] EBLD_OP_ED = 8'hed;
	localparam logic [7:0] EBLD_OP_DD = 8'hdd;
	localparam logic [7:0] EBLD_OP_FD = 8'hfd;
	localparam logic [7:0] EBLD_OP_ED_A_I = 8'h57;
	localparam logic [7:0] EBLD_OP_ED_I_A = 8'h47;
	localparam logic [7:0] EBLD_OP_ED_A_R = 8'h5f;
	localparam logic [7:0] EBLD_OP_ED_R_A = 8'h4f;
	localparam logic [7:0] EBLD_OP_ST_BC = 8'h02;
	localparam logic [7:0] EBLD_OP_ST_DE = 8'h12;
	localparam logic [7:0] EBLD_OP_LD_BC = 8'h0a;
	localparam logic [7:0] EBLD_OP_LD_DE = 8'h1a;
	localparam logic [7:0] EBLD_OP_LD_NN = 8'h3a;
	localparam logic [7:0] EBLD_OP_ST_N = 8'h36;
	localparam int EBLD_FS = 7;
	localparam int EBLD_FZ = 6;
	localparam int EBLD_FH = 4;
	localparam int EBLD_FPV = 2;
	localparam int EBLD_FN = 1;
	localparam int EBLD_FC = 0;
	localparam int EBLD_IXSEL = 5;
	localparam logic [5:0] EBLD_T_REG = 6'd4;
	localparam logic [5:0] EBLD_T_SPEC = 6'd9;
	localparam logic [5:0] EBLD_T_IMM = 6'd7;
	localparam logic [5:0] EBLD_T_IND = 6'd7;
	localparam logic [5:0] EBLD_T_STN = 6'd10;
	localparam logic [5:0] EBLD_T_IDX = 6'd19;
	localparam logic [5:0] EBLD_T_DIR = 6'd13;
	localparam logic [15:0] EBLD_RST_STEP = 16'h0008;
	localparam logic [7:0] EBLD_RESET_BYTE = 8'h00;
	localparam logic [15:0] EBLD_RESET_WORD = 16'h0000;
endpackage

// File: rtl/ebld_regfile.sv
// General register file: B C D E H L A with two read ports
`timescale 1ns/1ps
module ebld_regfile
	import ebld_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] rd_a_sel,
	input wire logic [2:0] rd_b_sel,
	input wire logic wr_en,
	input wire logic [2:0] wr_sel,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_a,
	output logic [7:0] rd_b
);
	logic [7:0] mem [0:7];

	// Storage, code 110 is never written
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++) begin
				mem[i] <= EBLD_RESET_BYTE;
			end
		end else if (wr_en && wr_sel != EBLD_R_MEM) begin
			mem[wr_sel] <= wr_data;
		end
	end

	// Registered read ports
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_a <= EBLD_RESET_BYTE;
			rd_b <= EBLD_RESET_BYTE;
		end else begin
			rd_a <= mem[rd_a_sel];
			rd_b <= mem[rd_b_sel];
		end
	end
endmodule

// File: rtl/ebld_fields.sv
// Shared operand field decoding: conditions, restart, displacement
`timescale 1ns/1ps
module ebld_fields
	import ebld_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] flags,
	input wire logic [2:0] condition_field,
	input wire logic [1:0] relative_condition_field,
	input wire logic [2:0] restart_field,
	input wire logic [15:0] base,
	input wire logic [7:0] disp,
	output logic cond_true,
	output logic rel_true,
	output logic [15:0] restart_addr,
	output logic [15:0] disp_addr
);
	// Condition test shared by both fields
	function automatic logic ebld_cond(input logic [2:0] c,
		input logic [7:0] f);
		logic bitv;
		bitv = 1'b0;
		case (c[2:1])
			2'h0: bitv = f[EBLD_FZ];
			2'h1: bitv = f[EBLD_FC];
			2'h2: bitv = f[EBLD_FPV];
			default: bitv = f[EBLD_FS];
		endcase
		return bitv == c[0];
	endfunction

	// Registered field results
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cond_true <= 1'b0;
			rel_true <= 1'b0;
			restart_addr <= EBLD_RESET_WORD;
			disp_addr <= EBLD_RESET_WORD;
		end else begin
			cond_true <= ebld_cond(condition_field, flags);
			rel_true <= ebld_cond({1'b0, relative_condition_field},
				flags);
			restart_addr <= 16'(restart_field) * EBLD_RST_STEP;
			disp_addr <= base + {{8{disp[7]}}, disp};
		end
	end
endmodule

// File: rtl/ebld_core.sv
// Eight-bit load decoder and executor
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
module ebld_core
	import ebld_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] mem_rdata,
	input wire logic interrupt_enable_copy,
	input wire logic int_pending,
	input wire logic [1:0] pair_field,
	input wire logic [1:0] stack_pair_field,
	input wire logic [2:0] condition_field,
	input wire logic [1:0] relative_condition_field,
	input wire logic [2:0] restart_field,
	output logic [15:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	output logic [7:0] flags,
	output logic [7:0] vector_reg,
	output logic [7:0] refresh_reg,
	output logic [15:0] ix,
	output logic [15:0] iy,
	output logic [15:0] pc,
	output logic [3:0] pair_sel,
	output logic [3:0] stack_pair_sel,
	output logic cond_true,
	output logic rel_true,
	output logic [15:0] restart_addr,
	output logic busy,
	output logic done,
	output logic [5:0] last_tstates
);
	typedef enum {ST_FETCH, ST_ED, ST_IDX, ST_DISP, ST_ADDR, ST_ARG1,
		ST_ARG2, ST_WAITRD, ST_EXEC, ST_PAD} ebld_state_t;

	ebld_state_t state;
	logic [7:0] opcode;
	logic is_index;
	logic iy_sel;
	logic [7:0] arg1;
	logic [7:0] arg2;
	logic [5:0] tcount;
	logic [5:0] tlimit;
	logic [7:0] acc;
	logic [7:0] rdata_a;
	logic [7:0] rdata_b;
	logic rf_wr;
	logic [2:0] rf_sel;
	logic [7:0] rf_data;
	logic [15:0] disp_addr;
	logic [15:0] hl;
	logic [15:0] bc;
	logic [15:0] de;
	logic int_seen;
	logic take_byte;

	// States that consume one instruction byte at the program counter
	assign take_byte = state == ST_FETCH || state == ST_ED ||
		state == ST_IDX || state == ST_DISP || state == ST_ARG1 ||
		state == ST_ARG2;

	// Register file reads feed the executing step
	ebld_regfile u_rf (
		.clk(clk),
		.rst_n(rst_n),
		.rd_a_sel(opcode[2:0]),
		.rd_b_sel(opcode[5:3]),
		.wr_en(rf_wr),
		.wr_sel(rf_sel),
		.wr_data(rf_data),
		.rd_a(rdata_a),
		.rd_b(rdata_b)
	);

	ebld_fields u_fd (
		.clk(clk),
		.rst_n(rst_n),
		.flags(flags),
		.condition_field(condition_field),
		.relative_condition_field(relative_condition_field),
		.restart_field(restart_field),
		.base(iy_sel ? iy : ix),
		.disp(arg1),
		.cond_true(cond_true),
		.rel_true(rel_true),
		.restart_addr(restart_addr),
		.disp_addr(disp_addr)
	);

	// Pair field decode, one-hot BC DE HL SP / AF
	function automatic logic [3:0] ebld_pair(input logic [1:0] p);
		return 4'h1 << p;
	endfunction

	// Pair selectors
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pair_sel <= 4'h0;
			stack_pair_sel <= 4'h0;
		end else begin
			pair_sel <= ebld_pair(pair_field);
			stack_pair_sel <= ebld_pair(stack_pair_field);
		end
	end

	// Shadow copies of pair contents for addressing, and of A
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hl <= EBLD_RESET_WORD;
			bc <= EBLD_RESET_WORD;
			de <= EBLD_RESET_WORD;
			acc <= EBLD_RESET_BYTE;
		end else if (rf_wr) begin
			case (rf_sel)
				EBLD_R_B: bc[15:8] <= rf_data;
				EBLD_R_C: bc[7:0] <= rf_data;
				EBLD_R_D: de[15:8] <= rf_data;
				EBLD_R_E: de[7:0] <= rf_data;
				EBLD_R_H: hl[15:8] <= rf_data;
				EBLD_R_L: hl[7:0] <= rf_data;
				EBLD_R_A: acc <= rf_data;
				default: ;
			endcase
		end
	end

	// Interrupt arrival while an instruction is in flight
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			int_seen <= 1'b0;
		end else if (state == ST_FETCH) begin
			int_seen <= 1'b0;
		end else if (int_pending) begin
			int_seen <= 1'b1;
		end
	end

	// T-state counter, one per clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tcount <= 6'd0;
		end else if (state == ST_FETCH && !busy) begin
			tcount <= 6'd1;
		end else begin
			tcount <= tcount + 6'd1;
		end
	end

	// Fixed registers: index pointers and program counter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ix <= EBLD_RESET_WORD;
			iy <= EBLD_RESET_WORD;
			pc <= EBLD_RESET_WORD;
		end else if (take_byte) begin
			pc <= pc + 16'h0001;
		end
	end

	// Sequencer and execution
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= ST_FETCH;
			opcode <= EBLD_RESET_BYTE;
			is_index <= 1'b0;
			iy_sel <= 1'b0;
			arg1 <= EBLD_RESET_BYTE;
			arg2 <= EBLD_RESET_BYTE;
			tlimit <= EBLD_T_REG;
			flags <= EBLD_RESET_BYTE;
			vector_reg <= EBLD_RESET_BYTE;
			refresh_reg <= EBLD_RESET_BYTE;
			mem_addr <= EBLD_RESET_WORD;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_wdata <= EBLD_RESET_BYTE;
			rf_wr <= 1'b0;
			rf_sel <= EBLD_R_A;
			rf_data <= EBLD_RESET_BYTE;
			busy <= 1'b0;
			done <= 1'b0;
			last_tstates <= 6'd0;
		end else begin
			rf_wr <= 1'b0;
			mem_wr <= 1'b0;
			done <= 1'b0;
			mem_rd <= 1'b0;
			if (take_byte) begin
				mem_addr <= pc + 16'h0001; // Next instruction byte
			end
			case (state)
				ST_FETCH: begin
					// Opcode byte on mem_rdata
					busy <= 1'b1;
					opcode <= mem_rdata;
					is_index <= 1'b0;
					if (mem_rdata == EBLD_OP_DD || mem_rdata == EBLD_OP_FD) begin
						is_index <= 1'b1;
						iy_sel <= mem_rdata[EBLD_IXSEL];
						state <= ST_IDX;
					end else if (mem_rdata == EBLD_OP_ED) begin
						state <= ST_ED;
					end else if (mem_rdata[7:6] == 2'h1) begin
						tlimit <= (mem_rdata[2:0] == EBLD_R_MEM ||
							mem_rdata[5:3] == EBLD_R_MEM) ? EBLD_T_IND
							: EBLD_T_REG;
						state <= ST_WAITRD;
					end else if (mem_rdata[7:6] == 2'h0 &&
						mem_rdata[2:0] == EBLD_R_MEM) begin
						tlimit <= mem_rdata == EBLD_OP_ST_N ? EBLD_T_STN
							: EBLD_T_IMM;
						state <= ST_ARG1;
					end else if (mem_rdata == EBLD_OP_LD_NN) begin
						tlimit <= EBLD_T_DIR;
						state <= ST_ARG1;
					end else begin
						tlimit <= EBLD_T_IND;
						state <= ST_WAITRD;
					end
					mem_rd <= 1'b1;
				end
				ST_ED: begin
					opcode <= mem_rdata;
					tlimit <= EBLD_T_SPEC;
					state <= ST_EXEC;
				end
				ST_IDX: begin
					opcode <= mem_rdata;
					tlimit <= EBLD_T_IDX;
					mem_rd <= 1'b1;
					state <= ST_DISP;
				end
				ST_DISP: begin
					arg1 <= mem_rdata;
					mem_rd <= 1'b1;
					state <= opcode == EBLD_OP_ST_N ? ST_ARG2 : ST_ADDR;
				end
				ST_ADDR: begin
					// Let the indexed sum settle
					state <= ST_WAITRD;
				end
				ST_ARG1: begin
					arg1 <= mem_rdata;
					mem_rd <= 1'b1;
					state <= opcode == EBLD_OP_LD_NN ? ST_ARG2 : ST_WAITRD;
				end
				ST_ARG2: begin
					arg2 <= mem_rdata;
					state <= ST_WAITRD;
				end
				ST_WAITRD: begin
					// Drive operand address
					if (is_index) begin
						mem_addr <= disp_addr;
					end else if (opcode == EBLD_OP_LD_NN) begin
						mem_addr <= {arg2, arg1};
					end else if (opcode == EBLD_OP_ST_BC ||
						opcode == EBLD_OP_LD_BC) begin
						mem_addr <= bc;
					end else if (opcode == EBLD_OP_ST_DE ||
						opcode == EBLD_OP_LD_DE) begin
						mem_addr <= de;
					end else begin
						mem_addr <= hl;
					end
					state <= ST_EXEC;
				end
				ST_EXEC: begin
					rf_sel <= opcode[5:3];
					if (opcode == EBLD_OP_ED_I_A && tlimit == EBLD_T_SPEC) begin
						vector_reg <= acc;
					end else if (opcode == EBLD_OP_ED_R_A &&
						tlimit == EBLD_T_SPEC) begin
						refresh_reg <= acc;
					end else if ((opcode == EBLD_OP_ED_A_I ||
						opcode == EBLD_OP_ED_A_R) && tlimit == EBLD_T_SPEC) begin
						rf_wr <= 1'b1;
						rf_sel <= EBLD_R_A;
						rf_data <= opcode == EBLD_OP_ED_A_I ? vector_reg
							: refresh_reg;
						flags[EBLD_FS] <= opcode == EBLD_OP_ED_A_I ?
							vector_reg[7] : refresh_reg[7];
						flags[EBLD_FZ] <= (opcode == EBLD_OP_ED_A_I ?
							vector_reg : refresh_reg) == 8'h00;
						flags[EBLD_FH] <= 1'b0;
						flags[EBLD_FN] <= 1'b0;
						flags[EBLD_FPV] <= interrupt_enable_copy &&
							!int_seen && !int_pending;
					end else if (opcode[7:6] == 2'h1 &&
						opcode[5:3] == EBLD_R_MEM) begin
						mem_wr <= 1'b1;
						mem_wdata <= rdata_a;
					end else if (opcode[7:6] == 2'h1 &&
						opcode[2:0] == EBLD_R_MEM) begin
						rf_wr <= 1'b1;
						rf_data <= mem_rdata;
					end else if (opcode[7:6] == 2'h1) begin
						rf_wr <= 1'b1;
						rf_data <= rdata_a;
					end else if (opcode == EBLD_OP_ST_N) begin
						mem_wr <= 1'b1;
						mem_wdata <= is_index ? arg2 : arg1;
					end else if (opcode == EBLD_OP_ST_BC ||
						opcode == EBLD_OP_ST_DE) begin
						mem_wr <= 1'b1;
						mem_wdata <= acc;
					end else if (opcode[7:6] == 2'h0 &&
						opcode[2:0] == EBLD_R_MEM &&
						opcode != EBLD_OP_LD_NN) begin
						rf_wr <= 1'b1;
						rf_data <= arg1;
					end else begin
						rf_wr <= 1'b1;
						rf_sel <= EBLD_R_A;
						rf_data <= mem_rdata;
					end
					state <= ST_PAD;
				end
				ST_PAD: begin
					// Hold until the documented T-state count
					mem_addr <= pc;
					if (tcount >= tlimit - 6'd1) begin
						busy <= 1'b0;
						done <= 1'b1;
						last_tstates <= tcount + 6'd1;
						state <= ST_FETCH;
					end
				end
				default: state <= ST_FETCH;
			endcase
		end
	end

	// Completion tied to documented counts
	AST_LOAD_TIME: assert property (@(posedge clk) disable iff (!rst_n)
		done |-> last_tstates == tlimit)
		else $error("instruction length wrong");
	AST_FLAGS_KEPT: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ST_EXEC && opcode[7:6] == 2'h1 && tlimit != EBLD_T_SPEC)
		|=> $stable(flags))
		else $error("flags changed by plain load");
	AST_VEC_HN: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ST_EXEC && tlimit == EBLD_T_SPEC &&
		opcode == EBLD_OP_ED_A_I) |=> !flags[EBLD_FH] && !flags[EBLD_FN])
		else $error("H or N not cleared");
	AST_VEC_STORE: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ST_EXEC && tlimit == EBLD_T_SPEC &&
		opcode == EBLD_OP_ED_I_A) |=> vector_reg == $past(acc))
		else $error("vector register not loaded");
	AST_REF_STORE: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ST_EXEC && tlimit == EBLD_T_SPEC &&
		opcode == EBLD_OP_ED_R_A) |=> refresh_reg == $past(acc))
		else $error("refresh register not loaded");
	AST_IDX_TIME: assert property (@(posedge clk) disable iff (!rst_n)
		(done && is_index) |-> last_tstates == EBLD_T_IDX)
		else $error("indexed load length wrong");
	AST_DIR_TIME: assert property (@(posedge clk) disable iff (!rst_n)
		(done && opcode == EBLD_OP_LD_NN) |-> last_tstates == EBLD_T_DIR)
		else $error("direct load length wrong");
	AST_NO_MEMREG: assert property (@(posedge clk) disable iff (!rst_n)
		rf_wr |-> rf_sel != EBLD_R_MEM)
		else $error("code 110 written as register");
endmodule

// File: verification/ebld_mem_model.sv
// Program and data memory model facing the load decoder
`timescale 1ns/1ps
module ebld_mem_model (
	input wire logic clk,
	input wire logic [15:0] mem_addr,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];
	// Filler byte is a harmless copy of B into B
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h40;
		end
	end
	// Array output follows the address
	assign mem_rdata = mem[mem_addr];
	// Store cycles land on the rising edge
	always @(posedge clk) begin
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
		end
	end
endmodule

// File: verification/eight_bit_load_decoder_test.sv
// Self-checking bench for the eight-bit load decoder
`timescale 1ns/1ps
module eight_bit_load_decoder_test
	import ebld_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] mem_rdata;
	logic interrupt_enable_copy = 1'b1;
	logic int_pending = 1'b0;
	logic [1:0] pair_field = 2'h0;
	logic [1:0] stack_pair_field = 2'h0;
	logic [2:0] condition_field = 3'h0;
	logic [1:0] relative_condition_field = 2'h0;
	logic [2:0] restart_field = 3'h0;
	logic [15:0] mem_addr, ix, iy, pc, restart_addr;
	logic mem_rd, mem_wr, cond_true, rel_true, busy, done;
	logic [7:0] mem_wdata, flags, vector_reg, refresh_reg;
	logic [3:0] pair_sel, stack_pair_sel;
	logic [5:0] last_tstates;
	logic [7:0] code [$];
	int err_total = 0;
	int n_compared = 0;

	always #2.5 clk = ~clk;

	ebld_core dut (.clk(clk), .rst_n(rst_n), .mem_rdata(mem_rdata),
		.interrupt_enable_copy(interrupt_enable_copy),
		.int_pending(int_pending), .pair_field(pair_field),
		.stack_pair_field(stack_pair_field),
		.condition_field(condition_field),
		.relative_condition_field(relative_condition_field),
		.restart_field(restart_field), .mem_addr(mem_addr),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.flags(flags), .vector_reg(vector_reg),
		.refresh_reg(refresh_reg), .ix(ix), .iy(iy), .pc(pc),
		.pair_sel(pair_sel), .stack_pair_sel(stack_pair_sel),
		.cond_true(cond_true), .rel_true(rel_true),
		.restart_addr(restart_addr), .busy(busy), .done(done),
		.last_tstates(last_tstates));

	ebld_mem_model mem_m (.clk(clk), .mem_addr(mem_addr), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		if (err_total == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Load a program at address zero under reset, then release
	task automatic boot;
		@(posedge clk);
		rst_n <= 1'b0;
		for (int i = 0; i < code.size(); i++) begin
			mem_m.mem[i] = code[i];
		end
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
	endtask

	// Wait for the end of one instruction, check its T-state count
	task automatic st(input logic [5:0] t);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (done !== 1'b1 && n < 40);
		if (n >= 40) chk(16'(done), 16'h1);
		if (t != 6'h0) chk(16'(last_tstates), 16'(t));
	endtask

	// Memory location holds the stored byte once the write settles
	task automatic wc(input logic [15:0] a, input logic [7:0] d);
		repeat (2) @(posedge clk);
		#1;
		chk(16'(mem_m.mem[a]), 16'(d));
	endtask

	function automatic int fbit(input logic [1:0] k);
		case (k)
			2'h0: return EBLD_FZ;
			2'h1: return EBLD_FC;
			2'h2: return EBLD_FPV;
			default: return EBLD_FS;
		endcase
	endfunction

	// Sweep every field code against the given flag byte
	task automatic fields(input logic [7:0] f);
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			@(posedge clk);
			condition_field <= c;
			relative_condition_field <= c[1:0];
			restart_field <= c;
			pair_field <= c[1:0];
			stack_pair_field <= c[1:0];
			repeat (2) @(posedge clk);
			#1;
			chk(16'(cond_true), 16'(f[fbit(c[2:1])] == c[0]));
			chk(16'(rel_true), 16'(f[fbit({1'b0, c[1]})] == c[0]));
			chk(16'(pair_sel), 16'h1 << c[1:0]);
			chk(16'(stack_pair_sel), 16'h1 << c[1:0]);
			chk(restart_addr, {10'h0, c, 3'h0});
		end
	endtask

	task automatic s_regs;
		logic [7:0] v [7] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h80, 8'h40, 8'h77};
		code = '{8'h06, 8'h11, 8'h0e, 8'h22, 8'h16, 8'h33, 8'h1e, 8'h44,
			8'h3e, 8'h77, 8'h26, 8'h80, 8'h2e, 8'h40, 8'h70, 8'h71, 8'h72,
			8'h73, 8'h74, 8'h75, 8'h77, 8'h50, 8'h72};
		boot();
		repeat (7) st(EBLD_T_IMM);
		for (int i = 0; i < 7; i++) begin
			st(6'h0);
			wc(16'h8040, v[i]);
		end
		st(EBLD_T_REG);
		st(6'h0);
		wc(16'h8040, 8'h11);
		chk(16'(flags), 16'h0);
		fields(8'h00);
	endtask

	task automatic s_mem;
		mem_m.mem[16'h0100] = 8'h3c;
		mem_m.mem[16'h0200] = 8'hc3;
		mem_m.mem[16'h0201] = 8'ha6;
		mem_m.mem[16'h1234] = 8'h5e;
		code = '{8'h26, 8'h01, 8'h2e, 8'h00, 8'h46, 8'h2e, 8'h10, 8'h70,
			8'h06, 8'h02, 8'h0e, 8'h00, 8'h0a, 8'h77, 8'h3a, 8'h34, 8'h12,
			8'h77, 8'h16, 8'h02, 8'h1e, 8'h01, 8'h1a, 8'h77, 8'h02};
		boot();
		repeat (2) st(EBLD_T_IMM);
		st(EBLD_T_IND);
		st(EBLD_T_IMM);
		st(6'h0);
		wc(16'h0110, 8'h3c);
		repeat (2) st(EBLD_T_IMM);
		st(EBLD_T_IND);
		st(6'h0);
		wc(16'h0110, 8'hc3);
		st(EBLD_T_DIR);
		st(6'h0);
		wc(16'h0110, 8'h5e);
		repeat (2) st(EBLD_T_IMM);
		st(EBLD_T_IND);
		st(6'h0);
		wc(16'h0110, 8'ha6);
		st(EBLD_T_IND);
		wc(16'h0200, 8'ha6);
	endtask

	task automatic s_idx;
		code = '{8'h3e, 8'h5c, 8'hdd, 8'h36, 8'hfe, 8'h99, 8'hfd, 8'h36,
			8'h7f, 8'haa, 8'hdd, 8'h77, 8'h80, 8'hdd, 8'h46, 8'hfe, 8'h70,
			8'hfd, 8'h7e, 8'h7f, 8'h12};
		boot();
		st(EBLD_T_IMM);
		st(EBLD_T_IDX);
		wc(16'hfffe, 8'h99);
		st(EBLD_T_IDX);
		wc(16'h007f, 8'haa);
		st(EBLD_T_IDX);
		wc(16'hff80, 8'h5c);
		st(EBLD_T_IDX);
		st(6'h0);
		wc(16'h0000, 8'h99);
		st(EBLD_T_IDX);
		st(EBLD_T_IND);
		wc(16'h0000, 8'haa);
		chk(ix, 16'h0);
		chk(iy, 16'h0);
	endtask

	task automatic s_spec;
		code = '{8'h3e, 8'h80, 8'hed, 8'h47, 8'hed, 8'h57, 8'hed, 8'h4f,
			8'hed, 8'h5f, 8'h47, 8'h3e, 8'h00, 8'hed, 8'h47, 8'hed, 8'h57,
			8'hed, 8'h5f, 8'hed, 8'h4f, 8'h3e, 8'h00, 8'hed, 8'h57};
		interrupt_enable_copy <= 1'b1;
		boot();
		st(EBLD_T_IMM);
		st(EBLD_T_SPEC);
		chk({vector_reg, flags}, 16'h8000);
		st(EBLD_T_SPEC);
		chk(16'(flags), 16'h84);
		st(EBLD_T_SPEC);
		chk({refresh_reg, flags}, 16'h8084);
		st(EBLD_T_SPEC);
		chk(16'(flags), 16'h84);
		st(EBLD_T_REG);
		chk(16'(flags), 16'h84);
		st(EBLD_T_IMM);
		st(EBLD_T_SPEC);
		chk({vector_reg, flags}, 16'h0084);
		interrupt_enable_copy <= 1'b0;
		st(EBLD_T_SPEC);
		chk(16'(flags), 16'h40);
		interrupt_enable_copy <= 1'b1;
		int_pending <= 1'b1;
		st(EBLD_T_SPEC);
		chk(16'(flags), 16'h80);
		int_pending <= 1'b0;
		st(EBLD_T_SPEC);
		chk(16'(refresh_reg), 16'h80);
		st(EBLD_T_IMM);
		st(EBLD_T_SPEC);
		chk(16'(flags), 16'h44);
		fields(8'h44);
	endtask

	initial begin
		repeat (6000) @(posedge clk);
		err_total++;
		end_sim();
	end

	initial begin
		s_regs();
		s_mem();
		s_idx();
		s_spec();
		end_sim();
	end
endmodule
